// ### hdl/dmas_seq.sv
// Summary of operation
// - Auto mode reloads parameters at block end.
// - Reload values taken only at block completion.
// - Select bit picks channel-0 or own reload set.
// - Select flag is bit 14, resets zero.
// - 8-bit frame counter decrements on frame end.
// - Frame counter reloads after last frame if auto.
// - Frame count zero means single frame.
// - 16-bit element counter; FFFF gives 65536.
// - Element counter reloads at every frame end.
// - Doubleword: two 16-bit halves, one element.
// - Index selects choose element/frame step registers.
// - Non-last transfers add the element step.
// - Last transfer of frame adds frame step.
// - Interrupt enable clear means no interrupt.
// - Buffering: full only, or half and full.
// - Multiframe: block end, or every frame end.
// - 4-bit code selects pacing event source.
// - Every channel can raise a CPU interrupt.
// - Routing field maps channels onto bits 6,7,10,11.
// - Reset routes shared inputs to serial ports.
`default_nettype none
module dmas_seq (
	input wire logic i_clk_sys, // Core clock, 100 MHz
	input wire logic i_rst, // Async reset, high
	input wire logic [6:0] i_addr, // Register word address
	input wire logic [15:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [15:0] o_rdata, // Read data, next cycle
	input wire logic [15:0] i_sync_evt, // Event pins by code
	input wire logic [3:0] i_serial_irq, // Serial port interrupts
	output logic o_req_valid, // Transfer request
	output dmas_pkg::dmas_req_t o_req, // Transfer contents
	input wire logic i_req_ready, // Transfer accepted
	output logic [3:0] o_cpu_irq_shared, // CPU bits 11,10,7,6
	output logic [1:0] o_cpu_irq_dma // Channels 5,4
);
	import dmas_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_RLD} dmas_state_t;

	// ==========================================================
	// Storage
	logic [15:0] prio_en, estep_a, estep_b, fstep_a, fstep_b;
	logic [15:0] src_a [NCH];
	logic [15:0] dst_a [NCH];
	logic [15:0] ecnt_a [NCH];
	logic [15:0] einit_a [NCH];
	logic [15:0] pos_a [NCH];
	logic [15:0] mcr_a [NCH];
	logic [7:0] fcnt_a [NCH];
	logic [3:0] sync_event_select_a [NCH];
	logic [NCH-1:0] dbl_a;
	logic [NCH-1:0] pend;
	dmas_state_t state;
	logic [2:0] cur, ptr, rstep;
	logic half;
	logic [15:0] rdata_q;
	logic mem_sel_q;
	logic [5:0] chan_irq;

	// ==========================================================
	// Bus decode
	wire in_glob = (i_addr[6:3] == 4'h0);
	wire in_ch = !i_addr[6] && (i_addr[5:3] != 3'h0) && (i_addr[5:3] != 3'h7);
	wire [2:0] ach = i_addr[5:3] - 3'h1;
	wire [2:0] aoff = i_addr[2:0];
	wire in_rld = i_addr[6] && !i_addr[5] && (i_addr[4:2] < 3'h6);
	wire wr_prio = i_wr && (i_addr == A_PRIO);
	wire wr_rld = i_wr && in_rld;
	wire [NCH-1:0] wr_ch = (i_wr && in_ch) ? NCH'(6'h01 << ach) : '0;

	// ==========================================================
	// Engine datapath for the current channel
	wire [15:0] mode = mcr_a[cur];
	wire auto_buffering = mode[MCR_ABU];
	wire last_half = !dbl_a[cur] || half;
	wire elem_last = !auto_buffering && (ecnt_a[cur] == 16'h0000);
	wire at_frame_end = elem_last && last_half;
	wire block_end = at_frame_end && (fcnt_a[cur] == 8'h00);
	wire take = (state == ST_XFER) && i_req_ready;
	wire elem_done = take && last_half;
	wire abu_full = (pos_a[cur] == ecnt_a[cur]);
	wire abu_half = (pos_a[cur] == {1'b0, ecnt_a[cur][15:1]});
	wire [2:0] rset = prio_en[PE_RSEL] ? cur : 3'h0;
	wire rld_cap = (state == ST_RLD) && (rstep != 3'h0);
	wire [1:0] rld_field = 2'(rstep - 3'h1);
	wire [4:0] eng_raddr = {rset, rstep[1:0]};
	wire [15:0] mem_eng_rd, mem_bus_rd;

	// Step value from an index select code
	function automatic logic [15:0] step_of(input logic [2:0] sel, input logic frame);
		logic [15:0] r;
		r = 16'h0000;
		unique case (sel)
			IX_INC: r = 16'h0001;
			IX_DEC: r = 16'hFFFF;
			IX_A: r = frame ? fstep_a : estep_a;
			IX_B: r = frame ? fstep_b : estep_b;
			default: r = 16'h0000;
		endcase
		return r;
	endfunction

	// Last transfer of a frame uses the frame step
	wire [15:0] next_src = src_a[cur] + step_of(mode[MCR_SOURCE_INDEX_SELECT +: 3], at_frame_end);
	wire [15:0] next_dst = dst_a[cur] + step_of(mode[MCR_DESTINATION_INDEX_SELECT +: 3], at_frame_end);
	wire [15:0] next_ecnt = elem_last ? einit_a[cur] : ecnt_a[cur] - 16'h0001;
	wire [7:0] next_fcnt = fcnt_a[cur] - 8'h01;
	wire [15:0] next_pos = abu_full ? 16'h0000 : pos_a[cur] + 16'h0001;

	// Interrupt events of the current channel
	wire mf_evt = block_end || (mode[MCR_IHALF] && at_frame_end);
	wire abu_evt = abu_full || (mode[MCR_IHALF] && abu_half);
	wire chan_evt = elem_done && mode[MCR_IEN] && (auto_buffering ? abu_evt : mf_evt);
	wire [5:0] next_irq = chan_evt ? 6'(6'h01 << cur) : 6'h00;
	wire stop_chan = elem_done && block_end && !mode[MCR_AUTO];
	wire [NCH-1:0] hw_clr_en = stop_chan ? NCH'(6'h01 << cur) : '0;

	// ==========================================================
	// Event pins: two-stage synchroniser, then rising edge
	logic [15:0] sy1, sy2, sy3;
	wire [15:0] evt_rise = sy2 & ~sy3;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sy1 <= 16'h0000;
			sy2 <= 16'h0000;
			sy3 <= 16'h0000;
		end else begin
			sy1 <= i_sync_evt;
			sy2 <= sy1;
			sy3 <= sy2;
		end
	end

	// ==========================================================
	// Round-robin choice of the next ready channel
	logic [NCH-1:0] ready_v;
	logic [2:0] pick;
	logic pick_ok;

	always_comb begin
		logic [3:0] t;
		t = 4'h0;
		pick = ptr;
		pick_ok = 1'b0;
		for (int i = 1; i <= NCH; i++) begin
			t = {1'b0, ptr} + 4'(i);
			if (t >= 4'(NCH)) begin
				t = t - 4'(NCH);
			end
			if (!pick_ok && ready_v[t[2:0]]) begin
				pick = t[2:0];
				pick_ok = 1'b1;
			end
		end
	end

	// ==========================================================
	// Sequencer state machine
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_IDLE;
			cur <= 3'h0;
			ptr <= 3'h0;
			half <= 1'b0;
			rstep <= 3'h0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					half <= 1'b0;
					if (pick_ok) begin
						cur <= pick;
						ptr <= pick;
						state <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (take && !last_half) begin
						half <= 1'b1;
					end else if (take && block_end && mode[MCR_AUTO]) begin
						rstep <= 3'h0;
						state <= ST_RLD;
					end else if (take) begin
						state <= ST_IDLE;
					end
				end
				ST_RLD: begin
					rstep <= rstep + 3'h1;
					if (rstep == 3'h4) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Global registers; hardware clears enables, a bus write wins
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			prio_en <= PE_RST;
			estep_a <= REG_RST;
			estep_b <= REG_RST;
			fstep_a <= REG_RST;
			fstep_b <= REG_RST;
		end else begin
			prio_en <= wr_prio ? i_wdata : (prio_en & ~{10'h000, hw_clr_en});
			if (i_wr && i_addr == A_ESTEP_A) estep_a <= i_wdata;
			if (i_wr && i_addr == A_ESTEP_B) estep_b <= i_wdata;
			if (i_wr && i_addr == A_FSTEP_A) fstep_a <= i_wdata;
			if (i_wr && i_addr == A_FSTEP_B) fstep_b <= i_wdata;
		end
	end

	// ==========================================================
	// Per-channel state
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		wire sel_c = (cur == 3'(c));
		wire take_c = take && sel_c;
		wire done_c = elem_done && sel_c;
		wire rld_c = rld_cap && sel_c;
		wire wr_src = wr_ch[c] && (aoff == O_SRC);
		wire wr_dst = wr_ch[c] && (aoff == O_DST);
		wire wr_ecnt = wr_ch[c] && (aoff == O_ECNT);
		wire wr_sfc = wr_ch[c] && (aoff == O_SFC);
		wire evt_c = (sync_event_select_a[c] != SYNC_EVENT_SELECT_NONE) && !(sync_event_select_a[c] inside {[4'h8:4'hC]}) && evt_rise[sync_event_select_a[c]];
		// Reserved codes are masked even if their pin toggles, so the channel waits
		assign ready_v[c] = prio_en[c] && ((sync_event_select_a[c] == SYNC_EVENT_SELECT_NONE) || pend[c]);

		// Addresses: bus, then reload, then engine step
		always_ff @(posedge i_clk_sys or posedge i_rst) begin
			if (i_rst) begin
				src_a[c] <= REG_RST;
				dst_a[c] <= REG_RST;
			end else begin
				if (wr_src) src_a[c] <= i_wdata;
				else if (rld_c && rld_field == F_SRC) src_a[c] <= mem_eng_rd;
				else if (take_c) src_a[c] <= next_src;
				if (wr_dst) dst_a[c] <= i_wdata;
				else if (rld_c && rld_field == F_DST) dst_a[c] <= mem_eng_rd;
				else if (take_c) dst_a[c] <= next_dst;
			end
		end

		// Counters and buffer position
		always_ff @(posedge i_clk_sys or posedge i_rst) begin
			if (i_rst) begin
				ecnt_a[c] <= REG_RST;
				einit_a[c] <= REG_RST;
				fcnt_a[c] <= FCNT_RST;
				pos_a[c] <= REG_RST;
			end else begin
				if (wr_ecnt) begin
					ecnt_a[c] <= i_wdata;
					einit_a[c] <= i_wdata;
				end else if (rld_c && rld_field == F_ECNT) begin
					ecnt_a[c] <= mem_eng_rd;
					einit_a[c] <= mem_eng_rd;
				end else if (done_c && !auto_buffering) begin
					ecnt_a[c] <= next_ecnt;
				end
				if (wr_sfc) fcnt_a[c] <= i_wdata[7:0];
				else if (rld_c && rld_field == F_FCNT) fcnt_a[c] <= mem_eng_rd[7:0];
				else if (done_c && at_frame_end && !block_end) fcnt_a[c] <= next_fcnt;
				if (wr_ecnt) pos_a[c] <= 16'h0000;
				else if (done_c && auto_buffering) pos_a[c] <= next_pos;
			end
		end

		// Mode, pacing select and pending event (set wins)
		always_ff @(posedge i_clk_sys or posedge i_rst) begin
			if (i_rst) begin
				mcr_a[c] <= REG_RST;
				sync_event_select_a[c] <= SYNC_EVENT_SELECT_NONE;
				dbl_a[c] <= 1'b0;
				pend[c] <= 1'b0;
			end else begin
				if (wr_ch[c] && aoff == O_MCR) mcr_a[c] <= i_wdata;
				if (wr_sfc) begin
					sync_event_select_a[c] <= i_wdata[SFC_SYNC_EVENT_SELECT +: 4];
					dbl_a[c] <= i_wdata[SFC_DBL];
				end
				pend[c] <= evt_c || (pend[c] && !done_c);
			end
		end
	end

	// ==========================================================
	// Reload store; engine port is read every cycle, its data captured only during reload
	dmas_rld_mem u_rld (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_we(wr_rld),
		.i_waddr(i_addr[4:0]),
		.i_wdata(i_wdata),
		.i_raddr_a(i_addr[4:0]),
		.o_rdata_a(mem_bus_rd),
		.i_raddr_b(eng_raddr),
		.o_rdata_b(mem_eng_rd)
	);

	// ==========================================================
	// Register read mux; unmapped words read zero
	logic [15:0] rd_mux;

	always_comb begin
		rd_mux = 16'h0000;
		if (in_glob) begin
			unique case (i_addr)
				A_PRIO: rd_mux = prio_en;
				A_ESTEP_A: rd_mux = estep_a;
				A_ESTEP_B: rd_mux = estep_b;
				A_FSTEP_A: rd_mux = fstep_a;
				A_FSTEP_B: rd_mux = fstep_b;
				default: rd_mux = 16'h0000;
			endcase
		end else if (in_ch) begin
			unique case (aoff)
				O_SRC: rd_mux = src_a[ach];
				O_DST: rd_mux = dst_a[ach];
				O_ECNT: rd_mux = ecnt_a[ach];
				O_SFC: rd_mux = {sync_event_select_a[ach], dbl_a[ach], 3'h0, fcnt_a[ach]};
				O_MCR: rd_mux = mcr_a[ach];
				default: rd_mux = 16'h0000;
			endcase
		end
	end

	// Read data stand one cycle after the strobe
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= 16'h0000;
			mem_sel_q <= 1'b0;
			chan_irq <= 6'h00;
		end else begin
			rdata_q <= i_rd ? rd_mux : 16'h0000;
			mem_sel_q <= i_rd && in_rld;
			chan_irq <= next_irq;
		end
	end

	assign o_rdata = mem_sel_q ? mem_bus_rd : rdata_q;

	// ==========================================================
	// Transfer request; fields hold while valid waits for ready
	assign o_req_valid = (state == ST_XFER);
	assign o_req = '{chan: cur, second_half: half, src: src_a[cur], dst: dst_a[cur]};

	// ==========================================================
	// Interrupt routing
	dmas_irq_route u_route (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_route(prio_en[PE_ROUTE +: 2]),
		.i_chan_irq(chan_irq),
		.i_serial_irq(i_serial_irq),
		.o_cpu_irq_shared(o_cpu_irq_shared),
		.o_cpu_irq_dma(o_cpu_irq_dma)
	);
endmodule
`default_nettype wire

// ### hdl/dmas_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants and types of the DMA sequencer
package dmas_pkg;
	localparam int NCH = 6;
	// ==========================================================
	// Register word addresses (7-bit word index)
	localparam logic [6:0] A_PRIO = 7'h00;
	localparam logic [6:0] A_ESTEP_A = 7'h01;
	localparam logic [6:0] A_ESTEP_B = 7'h02;
	localparam logic [6:0] A_FSTEP_A = 7'h03;
	localparam logic [6:0] A_FSTEP_B = 7'h04;
	// Channel c sits at 0x08 + 8*c, reload set c at 0x40 + 4*c
	localparam logic [2:0] O_SRC = 3'h0;
	localparam logic [2:0] O_DST = 3'h1;
	localparam logic [2:0] O_ECNT = 3'h2;
	localparam logic [2:0] O_SFC = 3'h3;
	localparam logic [2:0] O_MCR = 3'h4;
	localparam logic [1:0] F_SRC = 2'h0;
	localparam logic [1:0] F_DST = 2'h1;
	localparam logic [1:0] F_ECNT = 2'h2;
	localparam logic [1:0] F_FCNT = 2'h3;
	// ==========================================================
	// Field positions
	localparam int PE_RSEL = 14;
	localparam int PE_ROUTE = 6;
	localparam int MCR_AUTO = 15;
	localparam int MCR_IEN = 14;
	localparam int MCR_IHALF = 13;
	localparam int MCR_ABU = 12;
	localparam int MCR_SOURCE_INDEX_SELECT = 8;
	localparam int MCR_DESTINATION_INDEX_SELECT = 2;
	localparam int SFC_SYNC_EVENT_SELECT = 12;
	localparam int SFC_DBL = 11;
	// ==========================================================
	// Reset values and codes
	localparam logic [15:0] PE_RST = 16'h0000;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [7:0] FCNT_RST = 8'h00;
	localparam logic [2:0] IX_NONE = 3'h0;
	localparam logic [2:0] IX_INC = 3'h1;
	localparam logic [2:0] IX_DEC = 3'h2;
	localparam logic [2:0] IX_A = 3'h3;
	localparam logic [2:0] IX_B = 3'h4;
	localparam logic [3:0] SYNC_EVENT_SELECT_NONE = 4'h0;
	localparam logic [1:0] RT_SERIAL = 2'h0;
	localparam logic [1:0] RT_HIGH = 2'h1;
	localparam logic [1:0] RT_ALL = 2'h2;
	// One 16-bit transfer request
	typedef struct packed {
		logic [2:0] chan;
		logic second_half;
		logic [15:0] src;
		logic [15:0] dst;
	} dmas_req_t;
endpackage
`default_nettype wire

// ### hdl/dmas_rld_mem.sv
`default_nettype none
// ==========================================================
// Reload register store: one write port, two registered read ports
module dmas_rld_mem (
	input wire logic i_clk_sys, // Core clock
	input wire logic i_rst, // Async reset, high
	input wire logic i_we, // Write strobe
	input wire logic [4:0] i_waddr, // {channel, field}
	input wire logic [15:0] i_wdata, // Write data
	input wire logic [4:0] i_raddr_a, // Bus read address
	output logic [15:0] o_rdata_a, // Bus read data
	input wire logic [4:0] i_raddr_b, // Engine read address
	output logic [15:0] o_rdata_b // Engine read data
);
	logic [15:0] mem [32];

	// Storage has no reset; software loads it before use
	always_ff @(posedge i_clk_sys) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// Registered read ports
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rdata_a <= 16'h0000;
			o_rdata_b <= 16'h0000;
		end else begin
			o_rdata_a <= mem[i_raddr_a];
			o_rdata_b <= mem[i_raddr_b];
		end
	end
endmodule
`default_nettype wire

// ### hdl/dmas_irq_route.sv
`default_nettype none
// ==========================================================
// Routing of channel interrupts onto CPU interrupt inputs
module dmas_irq_route (
	input wire logic i_clk_sys, // Core clock
	input wire logic i_rst, // Async reset, high
	input wire logic [1:0] i_route, // Routing select
	input wire logic [5:0] i_chan_irq, // Channel pulses
	input wire logic [3:0] i_serial_irq, // {port1 tx, port1 rx, port2 tx, port2 rx}
	output logic [3:0] o_cpu_irq_shared, // CPU bits 11,10,7,6
	output logic [1:0] o_cpu_irq_dma // Channels 5,4
);
	import dmas_pkg::*;
	logic [3:0] next_shared;

	// Reserved code falls back to serial ports
	always_comb begin
		unique case (i_route)
			RT_HIGH: next_shared = {i_chan_irq[3:2], i_serial_irq[1:0]};
			RT_ALL: next_shared = i_chan_irq[3:0];
			default: next_shared = i_serial_irq;
		endcase
	end

	// Registered so outputs are glitch free
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_cpu_irq_shared <= 4'h0;
			o_cpu_irq_dma <= 2'h0;
		end else begin
			o_cpu_irq_shared <= next_shared;
			o_cpu_irq_dma <= i_chan_irq[5:4];
		end
	end
endmodule
`default_nettype wire

// ### tb/dmas_seq_asserts.sv
`default_nettype none
// ==========================================================
// Port checks of the DMA sequencer
module dmas_seq_asserts (
	input wire logic i_clk_sys, // Core clock
	input wire logic i_rst, // Async reset, high
	input wire logic [6:0] i_addr, // Word address
	input wire logic [15:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	input wire logic [15:0] o_rdata, // Read data
	input wire logic [15:0] i_sync_evt, // Event pins
	input wire logic [3:0] i_serial_irq, // Serial irqs
	input wire logic o_req_valid, // Request
	input wire dmas_pkg::dmas_req_t o_req, // Request body
	input wire logic i_req_ready, // Accept
	input wire logic [3:0] o_cpu_irq_shared, // Shared CPU bits
	input wire logic [1:0] o_cpu_irq_dma // Channels 5,4
);
	import dmas_pkg::*;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// Mirror of software-written control bits; hardware enable clears are not seen
	logic [1:0] route_q;
	logic sel_q;
	logic [5:0] en_q;
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			route_q <= 2'h0;
			sel_q <= 1'b0;
			en_q <= 6'h00;
		end else if (i_wr && i_addr == A_PRIO) begin
			route_q <= i_wdata[PE_ROUTE+:2];
			sel_q <= i_wdata[PE_RSEL];
			en_q <= i_wdata[5:0];
		end
	end
	// Past reset guard keeps the first edge, with reset-time inputs, out
	a_route_serial: assert property (!$past(i_rst) && $past(route_q) == RT_SERIAL |->
		o_cpu_irq_shared == $past(i_serial_irq)) else $error("shared lines not serial");
	a_route_high: assert property (!$past(i_rst) && $past(route_q) == RT_HIGH |->
		o_cpu_irq_shared[1:0] == $past(i_serial_irq[1:0])) else $error("low shared lines not serial");
	a_prio_read: assert property ($past(i_rd && i_addr == A_PRIO) |->
		o_rdata[PE_RSEL] == sel_q && o_rdata[7:6] == route_q) else $error("priority readback wrong");
	a_irq4_cause: assert property ($rose(o_cpu_irq_dma[0]) |->
		$past(o_req_valid && i_req_ready && o_req.chan == 3'h4, 2)) else $error("ch4 irq without transfer");
	a_irq5_cause: assert property ($rose(o_cpu_irq_dma[1]) |->
		$past(o_req_valid && i_req_ready && o_req.chan == 3'h5, 2)) else $error("ch5 irq without transfer");
	a_req_hold: assert property (o_req_valid && !i_req_ready |=>
		o_req_valid && $stable(o_req)) else $error("request dropped before accept");
	a_half_cause: assert property ($rose(o_req_valid && o_req.second_half) |->
		$past(o_req_valid && i_req_ready && !o_req.second_half)) else $error("second half out of order");
	a_gap_after: assert property (o_req_valid && i_req_ready |=>
		!o_req_valid || (o_req.second_half && !$past(o_req.second_half))) else $error("no idle gap");
	a_start_enabled: assert property ($rose(o_req_valid) |-> en_q[o_req.chan])
		else $error("disabled channel started");
	c_second_half: cover property (o_req_valid && i_req_ready && o_req.second_half);
	c_irq4: cover property ($rose(o_cpu_irq_dma[0]));
	c_stall: cover property (o_req_valid && !i_req_ready);
endmodule
`default_nettype wire

// ### tb/dmas_mem_model.sv
`default_nettype none
// ==========================================================
// Memory side: accepts transfers, promptly or after wait cycles
module dmas_mem_model (
	input wire logic i_clk_sys, // Core clock
	input wire logic i_rst, // Async reset, high
	input wire logic i_slow, // Insert wait cycles
	input wire logic i_valid, // Request present
	output logic o_ready // Accept strobe
);
	logic [1:0] wait_cnt;
	// Ready never leads a request and drops after each accept
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			wait_cnt <= 2'h0;
			o_ready <= 1'b0;
		end else begin
			o_ready <= i_valid && !o_ready && wait_cnt == 2'h0;
			if (o_ready) wait_cnt <= i_slow ? 2'h3 : 2'h0;
			else if (i_valid && wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
		end
	end
endmodule
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
bind dmas_seq dmas_seq_asserts chk (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sync_evt,
	.i_serial_irq, .o_req_valid, .o_req, .i_req_ready, .o_cpu_irq_shared, .o_cpu_irq_dma);
// ==========================================================
// Sequencer bench
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dmas_pkg::*;
	logic i_clk_sys = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_req_ready, slow = 1'b0;
	logic [6:0] i_addr = 7'h00;
	logic [15:0] i_wdata = 16'h0000, i_sync_evt = 16'h0000, o_rdata;
	logic [3:0] i_serial_irq = 4'h0, o_cpu_irq_shared;
	logic [1:0] o_cpu_irq_dma;
	logic o_req_valid, rd_q = 1'b0, track = 1'b1;
	dmas_req_t o_req;
	int errors = 0, tests_run = 0, irq_cnt = 0, w = 0, seed = 59129;
	logic [35:0] exp_req[$];
	logic [15:0] exp_rd[$], st[6];
	wire logic [5:0] irq_all = {o_cpu_irq_dma, o_cpu_irq_shared};
	always #5 i_clk_sys = ~i_clk_sys;
	dmas_seq uut (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sync_evt, .i_serial_irq,
		.o_req_valid, .o_req, .i_req_ready, .o_cpu_irq_shared, .o_cpu_irq_dma);
	dmas_mem_model mem (.i_clk_sys, .i_rst, .i_slow(slow), .i_valid(o_req_valid), .o_ready(i_req_ready));
	task automatic give_verdict();
		if (errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Results are matched in order against the notes left by the drivers
	always @(posedge i_clk_sys) begin
		rd_q <= i_rd;
		if (rd_q) check({20'h0, o_rdata}, {20'h0, exp_rd.pop_front()});
		if (o_req_valid && i_req_ready && track) begin
			if (exp_req.size() == 0) check(o_req, ~o_req);
			else check(o_req, exp_req.pop_front());
		end
		if (irq_all[w]) irq_cnt++;
	end
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd <= 1'b1;
		exp_rd.push_back(e);
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
	endtask
	// Channel c: addresses, element count, pacing and frames, mode
	task automatic cfg(input int c, input logic [15:0] s, d, n, f, m);
		logic [6:0] b;
		b = 7'h08 + 7'(8 * c);
		wr(b + 7'(O_SRC), s);
		wr(b + 7'(O_DST), d);
		wr(b + 7'(O_ECNT), n);
		wr(b + 7'(O_SFC), f);
		wr(b + 7'(O_MCR), m);
	endtask
	// Event pins pass a double flop, so each level is held well beyond it
	task automatic ev(input int c);
		@(posedge i_clk_sys);
		i_sync_evt[c] <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		i_sync_evt[c] <= 1'b0;
		repeat (20) @(posedge i_clk_sys);
	endtask
	task automatic drain();
		for (int k = 0; k < 300 && exp_req.size() != 0; k++) @(posedge i_clk_sys);
		if (exp_req.size() != 0) begin
			check(36'(exp_req.size()), 36'h0);
			give_verdict();
		end
	endtask
	// Paced run on one channel, counting pulses on the CPU line that carries it
	task automatic irq_case(input int c, r, wb, input logic [15:0] m, n, f, input int nev, ne);
		logic [15:0] pe;
		pe = 16'(r) << PE_ROUTE;
		track = 1'b0;
		w = wb;
		irq_cnt = 0;
		cfg(c, 16'h0100, 16'h0200, n, 16'h1000 | f, m);
		wr(A_PRIO, pe | (16'h0001 << c));
		repeat (nev) ev(1);
		check(36'(irq_cnt), 36'(ne));
		rd(A_PRIO, m[MCR_ABU] ? pe | (16'h0001 << c) : pe);
		wr(A_PRIO, pe);
		track = 1'b1;
	endtask
	initial begin
		repeat (5) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		rd(A_PRIO, PE_RST);
		wr(A_PRIO, 16'h4000);
		rd(A_PRIO, 16'h4000);
		repeat (16) @(posedge i_clk_sys) i_serial_irq <= 4'($random(seed));
		wr(A_PRIO, 16'h0040);
		repeat (16) @(posedge i_clk_sys) i_serial_irq <= 4'($random(seed));
		i_serial_irq <= 4'h0;
		for (int k = 0; k < 6; k++) st[k] = 16'($random(seed));
		wr(A_ESTEP_A, st[2]);
		wr(A_ESTEP_B, st[3]);
		wr(A_FSTEP_A, st[4]);
		wr(A_FSTEP_B, st[5]);
		// Two frames of two elements: element step mid-frame, frame step at frame end
		for (int k = 0; k < 4; k++) exp_req.push_back({3'h0, 1'b0, st[0] + 16'(k - k / 2) * st[2] +
			16'(k / 2) * st[4], st[1] + 16'(k - k / 2) * st[3] + 16'(k / 2) * st[5]});
		cfg(0, st[0], st[1], 16'h0001, 16'h0001, 16'(IX_A) << MCR_SOURCE_INDEX_SELECT | 16'(IX_B) << MCR_DESTINATION_INDEX_SELECT);
		wr(A_PRIO, 16'h0001);
		drain();
		rd(A_PRIO, 16'h0000);
		// Doubleword pairs under a slow memory
		slow <= 1'b1;
		for (int k = 0; k < 4; k++) exp_req.push_back({3'h4, 1'(k), st[0] + 16'(k), st[1] - 16'(k)});
		cfg(4, st[0], st[1], 16'h0001, 16'h0001 << SFC_DBL, 16'(IX_INC) << MCR_SOURCE_INDEX_SELECT | 16'(IX_DEC) << MCR_DESTINATION_INDEX_SELECT);
		wr(A_PRIO, 16'h0010);
		drain();
		// Every pacing code; reserved ones must never start the channel
		for (int c = 1; c < 16; c++) begin
			if (c < 8 || c > 12) exp_req.push_back({3'h2, 1'b0, st[c % 6], st[5 - c % 6]});
			cfg(2, st[c % 6], st[5 - c % 6], 16'h0000, 16'(c) << SFC_SYNC_EVENT_SELECT, 16'h0000);
			wr(A_PRIO, 16'h0004);
			ev(c);
			drain();
			wr(A_PRIO, 16'h0000);
		end
		// Auto reload from its own set, then from the shared set once the flag drops mid-block
		slow <= 1'b0;
		wr(7'h44, 16'hA000);
		wr(7'h45, 16'hB000);
		wr(7'h46, 16'h0001);
		wr(7'h47, 16'h0000);
		wr(7'h40, 16'hC000);
		wr(7'h41, 16'hD000);
		wr(7'h42, 16'h0000);
		wr(7'h43, 16'h0000);
		exp_req.push_back({3'h1, 1'b0, st[0], st[1]});
		exp_req.push_back({3'h1, 1'b0, 16'hA000, 16'hB000});
		exp_req.push_back({3'h1, 1'b0, 16'hA001, 16'hB001});
		exp_req.push_back({3'h1, 1'b0, 16'hC000, 16'hD000});
		cfg(1, st[0], st[1], 16'h0000, 16'h1000, 16'h8000 | 16'(IX_INC) << MCR_SOURCE_INDEX_SELECT | 16'(IX_INC) << MCR_DESTINATION_INDEX_SELECT);
		wr(A_PRIO, 16'h4002);
		ev(1);
		ev(1);
		wr(7'h44, 16'hE000);
		wr(A_PRIO, 16'h0002);
		ev(1);
		ev(1);
		drain();
		wr(A_PRIO, 16'h0000);
		// Interrupt modes and routing
		irq_case(4, 0, 4, 16'h6000, 16'h0001, 16'h0001, 4, 2);
		irq_case(4, 0, 4, 16'h4000, 16'h0001, 16'h0001, 4, 1);
		irq_case(4, 0, 4, 16'h2000, 16'h0001, 16'h0001, 4, 0);
		irq_case(4, 0, 4, 16'h7000, 16'h0003, 16'h0000, 4, 2);
		irq_case(4, 0, 4, 16'h5000, 16'h0003, 16'h0000, 4, 1);
		irq_case(4, 0, 4, 16'h3000, 16'h0003, 16'h0000, 4, 0);
		irq_case(5, 0, 5, 16'h4000, 16'h0000, 16'h0000, 1, 1);
		irq_case(0, 2, 0, 16'h4000, 16'h0000, 16'h0000, 1, 1);
		irq_case(1, 2, 1, 16'h4000, 16'h0000, 16'h0000, 1, 1);
		irq_case(2, 1, 2, 16'h4000, 16'h0000, 16'h0000, 1, 1);
		irq_case(3, 1, 3, 16'h4000, 16'h0000, 16'h0000, 1, 1);
		irq_case(0, 1, 0, 16'h4000, 16'h0000, 16'h0000, 1, 0);
		irq_case(0, 0, 0, 16'h4000, 16'h0000, 16'h0000, 1, 0);
		give_verdict();
	end
endmodule
`default_nettype wire
